// *** shared/zras_pkg.sv ***
// How it works
// - any zone enters Alarm; only suppression zones may reach Pre-Discharge
// - type A inputs raise Alarm only, never advance toward Pre-Discharge
// - one active type B or type C input raises Alarm
// - cross zoning advances only with one B alarm and one C alarm
// - type D advances only while two or more are active in the zone
// - one active type E input advances the zone alone
// - type F is manual release: advances and ignores every abort
// - entering Pre-Discharge loads the programmed countdown; release at its end
// - one system-wide abort type governs how abort holds back release
// - type 1: abort counts only if active at entry; countdown keeps running
// - type 1: after abort drops, later aborts ignored; release at completion
// - type 2: countdown runs; release needs countdown done and abort inactive
// - type 3: abort seen in Pre-Discharge releases when abort drops
// - type 4: release 10 s after abort drops; only first abort honoured
// - type 5: on abort drop countdown restarts from full programmed time
// - type 6: on abort drop 90 s verification then 30 s countdown
// - type 6: verification counts as abort; new abort extends countdown again
// - abort delays only automatic releases; manual release takes priority
//
// package of constants and carrier types for the zone release sequencer
// assumes a single 200 MHz clock and static configuration inputs
package zras_pkg;
   localparam int NZONES = 4;
   localparam int NINPUTS = 8;
   localparam int ZONE_W = 2;
   localparam int CNT_W = 8;
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 1000000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] T4_DELAY_S = 8'h0A;
   localparam logic [CNT_W-1:0] T6_VERIFY_S = 8'h5A;
   localparam logic [CNT_W-1:0] T6_COUNT_S = 8'h1E;
   localparam logic [2:0] ABORT_T1 = 3'h1;
   localparam logic [2:0] ABORT_T2 = 3'h2;
   localparam logic [2:0] ABORT_T3 = 3'h3;
   localparam logic [2:0] ABORT_T4 = 3'h4;
   localparam logic [2:0] ABORT_T5 = 3'h5;
   localparam logic [2:0] ABORT_T6 = 3'h6;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

   // pre-discharge type of an input, A to F in order
   typedef enum logic [2:0] {
      PD_A, PD_B, PD_C, PD_D, PD_E, PD_F
   } zras_pd_t;

   // zone sequencing states
   typedef enum logic [1:0] {
      ZS_NORMAL, ZS_ALARM, ZS_PREDIS, ZS_RELEASE
   } zras_state_t;

   // per-input configuration
   typedef struct packed {
      zras_pd_t pd_type;
      logic [ZONE_W-1:0] zone;
   } zras_in_cfg_t;

   // per-zone status
   typedef struct packed {
      logic alarm;
      logic predis;
      logic released;
      logic held;
      logic verify;
      logic manual;
      logic [CNT_W-1:0] remain;
   } zras_zone_st_t;
endpackage : zras_pkg

// *** src/zras_sequencer.sv ***
// per-zone release sequencer with pre-discharge and abort handling
// assumes alarm and abort pins are asynchronous and that configuration
// inputs are static while the panel runs
// abort type and countdown are only changed while reset is held
// abort codes 0 and 7 behave as type 2
`timescale 1ns/1ps
module zras_sequencer #(
   parameter int TICK_CYCLES = zras_pkg::TICK_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [zras_pkg::NINPUTS-1:0] i_in_active,
   input wire zras_pkg::zras_in_cfg_t [zras_pkg::NINPUTS-1:0] i_in_cfg,
   input wire logic [zras_pkg::NZONES-1:0] i_zone_supp,
   input wire logic i_abort,
   input wire logic [2:0] i_abort_type,
   input wire logic [zras_pkg::CNT_W-1:0] i_countdown_s,
   output logic o_tick,
   output logic [zras_pkg::NZONES-1:0] o_release,
   output zras_pkg::zras_zone_st_t [zras_pkg::NZONES-1:0] o_zone_status
);
   localparam int NZ = zras_pkg::NZONES;
   localparam int NI = zras_pkg::NINPUTS;
   localparam int CW = zras_pkg::CNT_W;
   localparam int ZW = zras_pkg::ZONE_W;

   // two-stage synchronisers for pins
   // the first stage is read only by the second, never by logic
   logic [NI-1:0] act_m_q;
   logic [NI-1:0] act_q;
   logic abort_m_q;
   logic abort_q;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         act_m_q <= '0;
         act_q <= '0;
         abort_m_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         act_m_q <= i_in_active;
         act_q <= act_m_q;
         abort_m_q <= i_abort;
         abort_q <= abort_m_q;
      end
   end

   // one second tick divider
   // restarts from zero after every reset, so timing is reset-relative
   // tick_q is high for one clock in every TICK_CYCLES clocks
   logic [31:0] div_q;
   logic [31:0] div_d;
   logic tick_q;
   logic tick_d;

   always_comb begin
      tick_d = 1'b0;
      div_d = div_q + 32'h1;
      if (div_q >= 32'(TICK_CYCLES - 1)) begin
         div_d = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;

   // one copy of the sequencer for each zone
   genvar z;
   generate
      for (z = 0; z < NZ; z++) begin : g_zone
         // per-zone state, countdown and abort bookkeeping
         zras_pkg::zras_state_t st_q;
         zras_pkg::zras_state_t st_d;
         logic [CW-1:0] cnt_q;
         logic [CW-1:0] cnt_d;
         logic hold_q;
         logic hold_d;
         logic used_q;
         logic used_d;
         logic verify_q;
         logic verify_d;
         logic manual_q;
         logic manual_d;
         logic any_al;
         logic has_b;
         logic has_c;
         logic has_e;
         logic has_f;
         logic [3:0] num_d;
         logic advance;
         logic ab;
         logic cnt0;
         logic dec_ok;
         logic [CW-1:0] cnt_dec;
         logic rel;

         // classify the active inputs that belong to this zone
         // type D inputs are counted, the others are only flagged
         always_comb begin
            any_al = 1'b0;
            has_b = 1'b0;
            has_c = 1'b0;
            has_e = 1'b0;
            has_f = 1'b0;
            num_d = 4'h0;
            for (int i = 0; i < NI; i++) begin
               if (act_q[i] && i_in_cfg[i].zone == ZW'(z)) begin
                  any_al = 1'b1;
                  case (i_in_cfg[i].pd_type)
                     zras_pkg::PD_B: has_b = 1'b1;
                     zras_pkg::PD_C: has_c = 1'b1;
                     zras_pkg::PD_D: num_d = num_d + 4'h1;
                     zras_pkg::PD_E: has_e = 1'b1;
                     zras_pkg::PD_F: has_f = 1'b1;
                     default: ;
                  endcase
               end
            end
            // type A never appears in the advance term
            advance = (has_b && has_c)
               || (num_d >= 4'h2)
               || has_e
               || has_f;
         end

         // countdown helpers
         // the counter stops at zero instead of wrapping
         assign cnt0 = (cnt_q == zras_pkg::CNT_RESET);
         assign dec_ok = tick_q && !cnt0;
         assign cnt_dec = dec_ok ? cnt_q - 8'h01 : cnt_q;
         // manual releases see no abort at all
         assign ab = abort_q && !manual_q && !has_f;

         // zone state and abort handling
         always_comb begin
            st_d = st_q;
            cnt_d = cnt_q;
            hold_d = hold_q;
            used_d = used_q;
            verify_d = verify_q;
            manual_d = manual_q;
            rel = 1'b0;
            case (st_q)
               // any input, type A included, raises alarm
               zras_pkg::ZS_NORMAL: begin
                  if (any_al) begin
                     st_d = zras_pkg::ZS_ALARM;
                  end
               end
               // only a suppression zone with its advance term moves on
               // an abort seen at entry arms the hold for every abort type unless a type F input is active
               zras_pkg::ZS_ALARM: begin
                  if (i_zone_supp[z] && advance) begin
                     st_d = zras_pkg::ZS_PREDIS;
                     cnt_d = i_countdown_s;
                     manual_d = has_f;
                     hold_d = abort_q && !has_f;
                     used_d = abort_q && !has_f;
                     verify_d = 1'b0;
                  end
               end
               // a manual input seen at any time here latches manual
               zras_pkg::ZS_PREDIS: begin
                  if (has_f) begin
                     manual_d = 1'b1;
                  end
                  if (manual_q || has_f) begin
                     hold_d = 1'b0;
                     verify_d = 1'b0;
                     cnt_d = cnt_dec;
                     rel = cnt0;
                  end else begin
                     // one abort type for all zones
                     case (i_abort_type)
                        // hold only from entry, gone once abort drops
                        zras_pkg::ABORT_T1: begin
                           cnt_d = cnt_dec;
                           if (!ab) begin
                              hold_d = 1'b0;
                           end
                           rel = cnt0 && !(hold_q && ab);
                        end
                        // any abort arms hold; its drop releases
                        zras_pkg::ABORT_T3: begin
                           cnt_d = cnt_dec;
                           if (ab) begin
                              hold_d = 1'b1;
                           end
                           rel = hold_q ? !ab : cnt0;
                        end
                        // first abort freezes; its drop loads the delay
                        zras_pkg::ABORT_T4: begin
                           if (ab && !used_q) begin
                              hold_d = 1'b1;
                              used_d = 1'b1;
                           end else if (hold_q && !ab) begin
                              hold_d = 1'b0;
                              cnt_d = zras_pkg::T4_DELAY_S;
                           end else if (!hold_q) begin
                              cnt_d = cnt_dec;
                           end
                           rel = cnt0 && !hold_q && !(ab && !used_q);
                        end
                        // abort reloads; its drop reloads once more
                        zras_pkg::ABORT_T5: begin
                           if (ab) begin
                              cnt_d = i_countdown_s;
                           end else if (hold_q) begin
                              cnt_d = i_countdown_s;
                           end else begin
                              cnt_d = cnt_dec;
                           end
                           hold_d = ab;
                           rel = cnt0 && !ab && !hold_q;
                        end
                        // abort freezes; its drop starts verification
                        zras_pkg::ABORT_T6: begin
                           if (ab && !verify_q) begin
                              hold_d = 1'b1;
                           end else if (hold_q) begin
                              hold_d = 1'b0;
                              verify_d = 1'b1;
                              cnt_d = zras_pkg::T6_VERIFY_S;
                           end else if (verify_q) begin
                              // abort is treated as held throughout
                              if (cnt0) begin
                                 verify_d = 1'b0;
                                 cnt_d = zras_pkg::T6_COUNT_S;
                              end else begin
                                 cnt_d = cnt_dec;
                              end
                           end else begin
                              cnt_d = cnt_dec;
                           end
                           rel = cnt0 && !hold_q && !verify_q && !ab;
                        end
                        default: begin
                           // type 2 and any unlisted code
                           // held follows the abort, release waits a clock
                           cnt_d = cnt_dec;
                           hold_d = ab;
                           rel = cnt0 && !ab && !hold_q;
                        end
                     endcase
                  end
                  // release is taken on the next edge and latched
                  if (rel) begin
                     st_d = zras_pkg::ZS_RELEASE;
                  end
               end
               // nothing but reset leaves release
               zras_pkg::ZS_RELEASE: begin
                  st_d = zras_pkg::ZS_RELEASE;
               end
               default: st_d = zras_pkg::ZS_NORMAL;
            endcase
         end

         // zone registers, cleared by reset only
         // hold, used, verify and manual matter only in pre-discharge
         always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               st_q <= zras_pkg::ZS_NORMAL;
               cnt_q <= zras_pkg::CNT_RESET;
               hold_q <= 1'b0;
               used_q <= 1'b0;
               verify_q <= 1'b0;
               manual_q <= 1'b0;
            end else begin
               st_q <= st_d;
               cnt_q <= cnt_d;
               hold_q <= hold_d;
               used_q <= used_d;
               verify_q <= verify_d;
               manual_q <= manual_d;
            end
         end

         // outputs straight from zone flip-flops
         // held means an abort is holding the zone back right now; under type 3 it also stays set after release
         assign o_release[z] = (st_q == zras_pkg::ZS_RELEASE);
         assign o_zone_status[z].alarm = (st_q != zras_pkg::ZS_NORMAL);
         assign o_zone_status[z].predis = (st_q == zras_pkg::ZS_PREDIS);
         assign o_zone_status[z].released = (st_q == zras_pkg::ZS_RELEASE);
         assign o_zone_status[z].held = hold_q;
         assign o_zone_status[z].verify = verify_q;
         assign o_zone_status[z].manual = manual_q;
         assign o_zone_status[z].remain = cnt_q;
      end
   endgenerate
endmodule : zras_sequencer

// *** tb/zras_field_model.sv ***
// detectors, manual stations and abort switch seen from the panel side
// assumes the bench changes commands just after a rising clock edge
`timescale 1ns/1ps
module zras_field_model (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_det_cmd,
   input wire logic i_abort_cmd,
   output logic [7:0] o_in_active,
   output logic o_abort
);
   // contacts follow the commands one clock later, open while reset
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_in_active <= 8'h00;
         o_abort <= 1'b0;
      end else begin
         o_in_active <= i_det_cmd;
         o_abort <= i_abort_cmd;
      end
   end
endmodule : zras_field_model

// *** tb/zras_sequencer_sva.sv ***
// port checker for the zone release sequencer
// assumes it is bound to the sequencer and sees only its ports
`timescale 1ns/1ps
module zras_sequencer_chk #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [zras_pkg::NZONES-1:0] i_zone_supp,
   input wire logic [2:0] i_abort_type,
   input wire logic o_tick,
   input wire logic [zras_pkg::NZONES-1:0] o_release,
   input wire zras_pkg::zras_zone_st_t [zras_pkg::NZONES-1:0] o_zone_status
);
   logic [31:0] gap_q;
   logic [31:0] gap_d;
   logic seen_q;
   logic seen_d;
   logic [3:0] al_v;
   logic [3:0] pd_v;
   logic [3:0] rel_v;
   logic [3:0] held_v;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // split status per zone and count clocks since the last tick
   always_comb begin
      for (int z = 0; z < 4; z++) begin
         al_v[z] = o_zone_status[z].alarm;
         pd_v[z] = o_zone_status[z].predis;
         rel_v[z] = o_zone_status[z].released;
         held_v[z] = o_zone_status[z].held;
      end
      gap_d = o_tick ? 32'h0 : gap_q + 32'h1;
      seen_d = seen_q | o_tick;
   end
   // tick helper registers
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_q <= 32'h0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= gap_d;
         seen_q <= seen_d;
      end
   end
   a_tick_spacing: assert property (seen_q |-> gap_q < TICK_CYCLES
      && (o_tick == (gap_q == TICK_CYCLES - 1))) else $error("tick spacing");
   a_release_latch: assert property ((~o_release & $past(o_release)) == 4'h0)
      else $error("release dropped");
   a_alarm_latch: assert property ((~al_v & $past(al_v)) == 4'h0)
      else $error("alarm dropped");
   a_release_status: assert property (o_release == rel_v)
      else $error("release status differs");
   a_nonsupp_hold: assert property (((pd_v | o_release) & ~i_zone_supp) == 4'h0)
      else $error("alarm zone advanced");
   a_release_after_pd: assert property
      ((o_release & ~$past(o_release) & ~$past(pd_v)) == 4'h0)
      else $error("release without pre-discharge");
   a_t2_held_block: assert property (i_abort_type == zras_pkg::ABORT_T2
      |-> (o_release & ~$past(o_release) & $past(held_v)) == 4'h0)
      else $error("release while held");
   a_remain_on_tick: assert property (o_zone_status[3].predis
      && !$past(o_zone_status[3].held)
      && o_zone_status[3].remain < $past(o_zone_status[3].remain)
      |-> o_tick || $past(o_tick)) else $error("countdown moved off tick");
endmodule : zras_sequencer_chk

bind zras_sequencer zras_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_zone_supp(i_zone_supp),
   .i_abort_type(i_abort_type), .o_tick(o_tick), .o_release(o_release),
   .o_zone_status(o_zone_status));

// *** tb/zras_sequencer_tb_top.sv ***
// bench for the zone release sequencer, zone 3 is the release zone
// assumes TICK_CYCLES cut to 4, so one second is four clocks
`timescale 1ns/1ps
module zras_sequencer_tb_top;
   localparam int TK = 4;
   logic i_ref_clk;
   logic i_rst;
   logic abort_cmd;
   logic i_abort;
   logic o_tick;
   logic [7:0] det_cmd;
   logic [7:0] i_in_active;
   logic [2:0] i_abort_type;
   logic [7:0] i_countdown_s;
   logic [3:0] o_release;
   logic [3:0] i_zone_supp;
   zras_pkg::zras_in_cfg_t [7:0] i_in_cfg;
   zras_pkg::zras_zone_st_t [3:0] o_zone_status;
   int err_total;
   int n_tests;
   zras_field_model i_zras_field_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_det_cmd(det_cmd), .i_abort_cmd(abort_cmd),
      .o_in_active(i_in_active), .o_abort(i_abort));
   zras_sequencer #(.TICK_CYCLES(TK)) i_zras_sequencer (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_in_active(i_in_active), .i_in_cfg(i_in_cfg),
      .i_zone_supp(i_zone_supp), .i_abort(i_abort),
      .i_abort_type(i_abort_type), .i_countdown_s(i_countdown_s),
      .o_tick(o_tick), .o_release(o_release), .o_zone_status(o_zone_status));
   // free running clock
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   task automatic print_verdict();
      if (err_total == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   // reset with a new abort type and countdown, all contacts open
   task automatic start(input logic [2:0] typ, input logic [7:0] cd);
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      i_abort_type <= typ;
      i_countdown_s <= cd;
      det_cmd <= 8'h00;
      abort_cmd <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
   endtask : start
   // zone 3 to pre-discharge, optional abort drop, release timed after it
   task automatic run(input logic [2:0] typ, input logic [7:0] cd,
      input logic [7:0] det, input logic ab, input int w, input logic dr,
      input int lo, input int hi);
      int n;
      logic seen_v;
      start(typ, cd);
      det_cmd <= det;
      abort_cmd <= ab;
      n = 0;
      while (o_zone_status[3].predis !== 1'b1 && n < 20) begin
         @(negedge i_ref_clk);
         n++;
      end
      check({15'h0000, n < 20}, 16'h0001);
      if (n >= 20) print_verdict();
      check({8'h00, o_zone_status[3].remain}, {8'h00, cd});
      check({15'h0, o_zone_status[3].held}, {15'h0, ab & ~det[6]});
      repeat (w) @(negedge i_ref_clk);
      @(posedge i_ref_clk);
      abort_cmd <= ab & ~dr;
      n = 0;
      seen_v = 1'b0;
      while (o_release[3] !== 1'b1 && n < 600) begin
         @(negedge i_ref_clk);
         seen_v = seen_v | o_zone_status[3].verify;
         n++;
      end
      check({15'h0000, n >= lo && n <= hi}, 16'h0001);
      check({15'h0, seen_v}, {15'h0, typ == 3'h6});
      check({15'h0, o_zone_status[3].manual}, {15'h0, det[6]});
      if (n >= 600) print_verdict();
      @(posedge i_ref_clk);
      det_cmd <= 8'h00;
      repeat (8) @(negedge i_ref_clk);
      check({15'h0000, o_release[3]}, 16'h0001);
   endtask : run
   // type A, cross zone, count zone and a plain alarm zone
   task automatic sc_adv();
      start(3'h2, 8'h05);
      det_cmd <= 8'h8B;
      repeat (24) @(negedge i_ref_clk);
      check({10'h000, o_zone_status[2].alarm, o_zone_status[1].alarm,
         o_zone_status[0].alarm, o_zone_status[2].predis,
         o_zone_status[1].predis, o_zone_status[0].predis},
         16'h0038);
      @(posedge i_ref_clk);
      det_cmd <= 8'h9F;
      repeat (10) @(negedge i_ref_clk);
      check({13'h0000, o_zone_status[2].predis, o_zone_status[1].predis,
         o_zone_status[0].predis}, 16'h0006);
   endtask : sc_adv
   // main sequence
   initial begin
      err_total = 0;
      n_tests = 0;
      i_rst = 1'b1;
      det_cmd = 8'h00;
      abort_cmd = 1'b0;
      i_abort_type = 3'h2;
      i_countdown_s = 8'h05;
      i_zone_supp = 4'hE;
      i_in_cfg = {zras_pkg::PD_E, 2'h0, zras_pkg::PD_F, 2'h3, zras_pkg::PD_E,
         2'h3, zras_pkg::PD_D, 2'h2, zras_pkg::PD_D, 2'h2, zras_pkg::PD_C,
         2'h1, zras_pkg::PD_B, 2'h1, zras_pkg::PD_A, 2'h2};
      sc_adv();
      run(3'h2, 8'h02, 8'h40, 1'b1, 0, 1'b0, 2, 16);
      run(3'h1, 8'h06, 8'h20, 1'b1, 8, 1'b1, 10, 24);
      run(3'h2, 8'h03, 8'h20, 1'b1, 60, 1'b1, 2, 8);
      run(3'h3, 8'h3C, 8'h20, 1'b1, 8, 1'b1, 2, 8);
      run(3'h4, 8'h03, 8'h20, 1'b1, 30, 1'b1, 36, 50);
      run(3'h5, 8'h06, 8'h20, 1'b1, 20, 1'b1, 22, 34);
      run(3'h6, 8'h02, 8'h20, 1'b1, 4, 1'b1, 470, 500);
      print_verdict();
   end
endmodule : zras_sequencer_tb_top
